/* logic/host_port_pkg.sv */
// package of constants shared by both ends of the parallel host port
package host_port_pkg;
  localparam int          AD_W        = 16;
  localparam int          ADDR_W      = 14;
  localparam int          CFG_W       = 3;
  localparam logic [2:0]  CFG_BYTE_SEL = 3'h7;
  localparam int          CLK_MHZ     = 40;
  localparam int          ACCESS_NS   = 75;
  localparam int          ACCESS_CYC  = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int          HOLD_NS     = 50;
  localparam int          HOLD_CYC    = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [15:0] DATA_RST    = 16'h0000;
  localparam logic [13:0] ADDR_RST    = 14'h0000;
endpackage : host_port_pkg

/* logic/host_port_if.sv */
// interface joining the host controller and the device's parallel port
`timescale 1ns/1ps
interface host_port_if;
  logic        chip_sel;
  logic        address_latch_strobe;
  logic        read_not_write;
  logic        low_byte_strobe;
  logic        high_byte_strobe;
  logic [15:0] ad_host_out;
  logic [15:0] ad_host_oe;
  logic [15:0] ad_dev_out;
  logic [15:0] ad_dev_oe;
  logic [15:0] ad_bus;

  // resolved bus level; an undriven line reads high as if pulled up
  genvar i;
  for (i = 0; i < 16; i++) begin : g_res
    assign ad_bus[i] = ad_dev_oe[i] ? ad_dev_out[i] :
                       ad_host_oe[i] ? ad_host_out[i] : 1'b1;
  end

  modport dev (
    input  chip_sel, address_latch_strobe, read_not_write,
    input  low_byte_strobe, high_byte_strobe, ad_bus,
    output ad_dev_out, ad_dev_oe
  );
  modport host (
    output chip_sel, address_latch_strobe, read_not_write,
    output low_byte_strobe, high_byte_strobe, ad_host_out, ad_host_oe,
    input  ad_bus
  );
endinterface : host_port_if

/* logic/parallel_host_port.sv */
// device end of the 16-bit multiplexed byte-select host port
`timescale 1ns/1ps
module parallel_host_port #(
  parameter int ACCESS_CYC = host_port_pkg::ACCESS_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        sys_reset,
  input  wire logic [2:0]  host_port_cfg_strap,
  host_port_if.dev         port,
  output logic             mem_req,
  output logic             mem_we,
  output logic [1:0]       mem_be,
  output logic [13:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic [15:0] mem_rdata,
  output logic             mode_active
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } acc_state_t;

  // strobes count only in this mode and with the device selected
  function automatic logic port_selected(input logic mode,
                                         input logic cs,
                                         input logic stb);
    return mode && cs && stb;
  endfunction : port_selected

  logic [4:0]  s1_q, s2_q;          // cs, al, rw, b0, b1 synchronisers
  logic        al_prev_q;
  logic        strobe_prev_q;
  logic [13:0] addr_q, addr_d;
  logic [15:0] rdata_q, rdata_d;
  logic        valid_q, valid_d;
  logic [7:0]  cnt_q, cnt_d;
  acc_state_t  st_q, st_d;
  logic        mode_q, mode_d;
  logic        strap_done_q;
  logic        req_q, req_d, we_q, we_d;
  logic [1:0]  be_q, be_d;
  logic [15:0] wdata_q, wdata_d;
  logic [15:0] oe_q, oe_d;
  logic [15:0] dout_q, dout_d;
  logic        cs_s, al_s, rw_s, b0_s, b1_s, any_s;

  // synchronised pin levels
  assign cs_s  = s2_q[0];
  assign al_s  = s2_q[1];
  assign rw_s  = s2_q[2];
  assign b0_s  = s2_q[3];
  assign b1_s  = s2_q[4];
  assign any_s = b0_s | b1_s;

  // two-stage synchronisers; first stage read only by second
  always_ff @(posedge sys_clk) begin
    s1_q <= {port.high_byte_strobe, port.low_byte_strobe,
             port.read_not_write, port.address_latch_strobe, port.chip_sel};
    s2_q <= s1_q;
  end

  // strap capture once after power-on reset only
  always_comb begin
    mode_d = mode_q;
    if (!strap_done_q)
      mode_d = (host_port_cfg_strap == host_port_pkg::CFG_BYTE_SEL);
  end

  // strap result held; a soft reset never reaches it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_q       <= 1'b0;
      strap_done_q <= 1'b0;
    end else begin
      mode_q       <= mode_d;
      strap_done_q <= 1'b1;
    end
  end

  // access engine: latch, request, read data hold
  always_comb begin
    addr_d  = addr_q;
    rdata_d = rdata_q;
    valid_d = valid_q;
    cnt_d   = cnt_q;
    st_d    = st_q;
    req_d   = 1'b0;
    we_d    = we_q;
    be_d    = be_q;
    wdata_d = wdata_q;
    // latch fall seen two clocks late; the host holds the address meanwhile
    if (port_selected(mode_q, cs_s, al_prev_q && !al_s) && !any_s)
      addr_d = port.ad_bus[13:0];
    case (st_q)
      ST_IDLE: begin
        if (port_selected(mode_q, cs_s, any_s) && !strobe_prev_q) begin
          req_d   = 1'b1;
          we_d    = !rw_s;
          be_d    = rw_s ? 2'b11 : {b1_s, b0_s};
          wdata_d = port.ad_bus;
          valid_d = 1'b0;
          cnt_d   = 8'(ACCESS_CYC);
          st_d    = rw_s ? ST_WAIT : ST_DONE;
        end
      end
      ST_WAIT: begin
        if (cnt_q > 8'h01)
          cnt_d = cnt_q - 8'h01;
        else begin
          rdata_d = mem_rdata;
          valid_d = 1'b1;
          st_d    = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!any_s)
          st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    // soft system reset drops the access but keeps the latched address
    if (sys_reset) begin
      st_d  = ST_IDLE;
      req_d = 1'b0;
    end
  end

  // access engine registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      addr_q        <= host_port_pkg::ADDR_RST;
      st_q          <= ST_IDLE;
      rdata_q       <= host_port_pkg::DATA_RST;
      valid_q       <= 1'b0;
      cnt_q         <= 8'h00;
      req_q         <= 1'b0;
      we_q          <= 1'b0;
      be_q          <= 2'b00;
      wdata_q       <= host_port_pkg::DATA_RST;
      al_prev_q     <= 1'b0;
      strobe_prev_q <= 1'b0;
    end else begin
      st_q          <= st_d;
      addr_q        <= addr_d;
      rdata_q       <= rdata_d;
      valid_q       <= valid_d;
      cnt_q         <= cnt_d;
      req_q         <= req_d;
      we_q          <= we_d;
      be_q          <= be_d;
      wdata_q       <= wdata_d;
      al_prev_q     <= al_s;
      strobe_prev_q <= any_s;
    end
  end

  // bus drive: only when selected, reading and strobed
  always_comb begin
    oe_d = 16'h0000;
    if (port_selected(mode_q, cs_s, rw_s && any_s))
      oe_d = 16'hFFFF;
    dout_d = 16'hFFFF;                // undefined until valid
    if (valid_d)
      dout_d = rdata_d;
  end

  // bus drive registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      oe_q   <= 16'h0000;
      dout_q <= host_port_pkg::DATA_RST;
    end else begin
      oe_q   <= oe_d;
      dout_q <= dout_d;
    end
  end

  // every output straight from a flip-flop
  assign port.ad_dev_oe  = oe_q;
  assign port.ad_dev_out = dout_q;
  assign mem_req         = req_q;
  assign mem_we          = we_q;
  assign mem_be          = be_q;
  assign mem_addr        = addr_q;
  assign mem_wdata       = wdata_q;
  assign mode_active     = mode_q;
endmodule : parallel_host_port

/* logic/host_port_master.sv */
// host controller end driving the byte-select multiplexed port
`timescale 1ns/1ps
module host_port_master #(
  parameter int HOLD_CYC = host_port_pkg::HOLD_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        use_chip_sel,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic        cmd_relatch,
  input  wire logic [1:0]  cmd_be,
  input  wire logic [13:0] cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  host_port_if.host        port
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_ADDR = 3'b001,
    H_AL   = 3'b010,
    H_SET  = 3'b011,
    H_STB  = 3'b100,
    H_END  = 3'b101
  } host_state_t;

  host_state_t st_q, st_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        wr_q, wr_d, cs_q, cs_d, al_q, al_d, rw_q, rw_d;
  logic [1:0]  be_q, be_d, stb_q, stb_d;
  logic [13:0] addr_q, addr_d;
  logic [15:0] wd_q, wd_d, out_q, out_d, oe_q, oe_d, rd_q, rd_d;
  logic        rv_q, rv_d;
  logic        ready_q, ready_d;

  // transfer sequencer
  always_comb begin
    st_d   = st_q;
    wr_d   = wr_q;
    be_d   = be_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    cs_d   = cs_q;
    al_d   = 1'b0;
    rw_d   = rw_q;
    stb_d  = 2'b00;
    out_d  = out_q;
    oe_d   = oe_q;
    rd_d   = rd_q;
    rv_d   = 1'b0;
    cnt_d  = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
    case (st_q)
      H_IDLE: begin
        cs_d = !use_chip_sel;
        if (cmd_valid) begin
          wr_d   = cmd_write;
          be_d   = cmd_be;
          addr_d = cmd_addr;
          wd_d   = cmd_wdata;
          cs_d   = 1'b1;
          st_d   = cmd_relatch ? H_ADDR : H_SET;
          out_d  = {2'b00, cmd_addr};
          oe_d   = cmd_relatch ? 16'hFFFF : 16'h0000;
          cnt_d  = 8'(HOLD_CYC);
        end
      end
      H_ADDR: begin
        al_d = 1'b1;
        if (cnt_q == 8'h00) begin
          st_d  = H_AL;
          cnt_d = 8'(HOLD_CYC);
        end
      end
      H_AL: begin
        // latch low, address still held for the device's late capture
        if (cnt_q == 8'h00) begin
          st_d  = H_SET;
          cnt_d = 8'(HOLD_CYC);
        end
      end
      H_SET: begin
        rw_d  = !wr_q;
        out_d = wd_q;
        oe_d  = wr_q ? 16'hFFFF : 16'h0000;
        if (cnt_q == 8'h00) begin
          st_d  = H_STB;
          cnt_d = 8'(4 * HOLD_CYC);
        end
      end
      H_STB: begin
        stb_d = be_q;
        if (cnt_q == 8'h00) begin
          rd_d  = port.ad_bus;
          rv_d  = !wr_q;
          st_d  = H_END;
          cnt_d = 8'(HOLD_CYC);
        end
      end
      H_END: begin
        if (cnt_q == 8'h00) begin
          oe_d = 16'h0000;
          st_d = H_IDLE;
        end
      end
      default: st_d = H_IDLE;
    endcase
    ready_d = (st_d == H_IDLE);
  end

  // sequencer registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q    <= H_IDLE;
      cnt_q   <= 8'h00;
      wr_q    <= 1'b0;
      be_q    <= 2'b00;
      addr_q  <= host_port_pkg::ADDR_RST;
      wd_q    <= host_port_pkg::DATA_RST;
      cs_q    <= 1'b0;
      al_q    <= 1'b0;
      rw_q    <= 1'b1;
      stb_q   <= 2'b00;
      out_q   <= host_port_pkg::DATA_RST;
      oe_q    <= 16'h0000;
      rd_q    <= host_port_pkg::DATA_RST;
      rv_q    <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      wr_q    <= wr_d;
      be_q    <= be_d;
      addr_q  <= addr_d;
      wd_q    <= wd_d;
      cs_q    <= cs_d;
      al_q    <= al_d;
      rw_q    <= rw_d;
      stb_q   <= stb_d;
      out_q   <= out_d;
      oe_q    <= oe_d;
      rd_q    <= rd_d;
      rv_q    <= rv_d;
      ready_q <= ready_d;
    end
  end

  assign port.chip_sel             = cs_q;
  assign port.address_latch_strobe = al_q;
  assign port.read_not_write       = rw_q;
  assign port.low_byte_strobe      = stb_q[0];
  assign port.high_byte_strobe     = stb_q[1];
  assign port.ad_host_out          = out_q;
  assign port.ad_host_oe           = oe_q;
  assign cmd_ready = ready_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rd_q;
endmodule : host_port_master

/* verif/host_port_chk.sv */
// concurrent checks on the signals of the host port interface
`timescale 1ns/1ps
module host_port_chk (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        chip_sel,
  input wire logic        address_latch_strobe,
  input wire logic        read_not_write,
  input wire logic        low_byte_strobe,
  input wire logic        high_byte_strobe,
  input wire logic [15:0] ad_host_out,
  input wire logic [15:0] ad_host_oe,
  input wire logic [15:0] ad_dev_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // either byte lane strobe high
  logic stb;
  assign stb = low_byte_strobe | high_byte_strobe;

  // read request seen at the pins, then device drives the word
  sequence rd_start;
    $rose(stb) && read_not_write && chip_sel;
  endsequence
  sequence dev_word;
    ad_dev_oe == 16'hFFFF;
  endsequence

  no_overlap_a: assert property (address_latch_strobe |-> !stb)
    else $error("latch strobe overlaps a byte strobe");
  latch_pulse_a: assert property (
    $rose(address_latch_strobe) |-> address_latch_strobe[*3])
    else $error("latch strobe pulse too short");
  host_release_a: assert property (
    read_not_write && stb |-> ad_host_oe == 16'h0000)
    else $error("host drives bus during read strobe");
  no_fight_a: assert property ((ad_dev_oe & ad_host_oe) == 16'h0000)
    else $error("both ends drive the bus");
  word_drive_a: assert property (
    ad_dev_oe == 16'h0000 || ad_dev_oe == 16'hFFFF)
    else $error("device drives part of the word");
  read_drive_a: assert property (rd_start |-> ##[1:6] dev_word)
    else $error("device never drives read data");
  idle_release_a: assert property (
    !stb [*4] |-> ad_dev_oe == 16'h0000)
    else $error("bus kept driven with strobes low");
  write_release_a: assert property (
    !read_not_write [*4] |-> ad_dev_oe == 16'h0000)
    else $error("bus driven while write selected");
  low_lane_a: assert property (
    !read_not_write && low_byte_strobe |-> &ad_host_oe[7:0])
    else $error("low lane not driven on low write");
  rw_hold_a: assert property (stb && $past(stb) |->
    $stable(read_not_write) && (read_not_write || $stable(ad_host_out)))
    else $error("direction or data moved inside strobe");
endmodule : host_port_chk

/* verif/mux16_byte_select_host_port_bench.sv */
// self-checking bench joining host and device ends of the port
`timescale 1ns/1ps
module mux16_byte_select_host_port_bench;
  typedef struct packed {
    logic        cs;
    logic        wr;
    logic        rl;
    logic [1:0]  be;
    logic [13:0] addr;
    logic [15:0] wd;
    logic [13:0] ea;
  } row_t;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        sys_reset = 1'b0;
  logic [2:0]  strap = 3'h7;
  logic        use_chip_sel = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic        cmd_relatch = 1'b0;
  logic [1:0]  cmd_be = 2'h0;
  logic [13:0] cmd_addr = 14'h0000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [15:0] mem_rdata = 16'h0000;
  logic        cmd_ready, rsp_valid, mem_req, mem_we, mode_active;
  logic [15:0] rsp_rdata, mem_wdata;
  logic [1:0]  mem_be;
  logic [13:0] mem_addr;
  int          err_total = 0;
  int          samples_checked = 0;
  int          req_count = 0;
  int          cyc = 0;
  // cs, write, relatch, lanes, address, data, expected latched address
  row_t        rows [7] = '{
    {1'b1, 1'b1, 1'b1, 2'h1, 14'h0123, 16'h00A5, 14'h0123},
    {1'b1, 1'b1, 1'b0, 2'h2, 14'h3FFF, 16'h5A00, 14'h0123},
    {1'b1, 1'b1, 1'b1, 2'h3, 14'h3FFF, 16'hBEEF, 14'h3FFF},
    {1'b1, 1'b0, 1'b0, 2'h1, 14'h0000, 16'h0000, 14'h3FFF},
    {1'b1, 1'b0, 1'b1, 2'h2, 14'h0ACE, 16'h0000, 14'h0ACE},
    {1'b0, 1'b1, 1'b1, 2'h3, 14'h1234, 16'hC3C3, 14'h1234},
    {1'b0, 1'b0, 1'b0, 2'h3, 14'h0FF0, 16'h0000, 14'h1234}};

  host_port_if port_if ();

  parallel_host_port parallel_host_port_i (
    .sys_clk            (sys_clk),
    .reset              (reset),
    .sys_reset          (sys_reset),
    .host_port_cfg_strap(strap),
    .port               (port_if),
    .mem_req            (mem_req),
    .mem_we             (mem_we),
    .mem_be             (mem_be),
    .mem_addr           (mem_addr),
    .mem_wdata          (mem_wdata),
    .mem_rdata          (mem_rdata),
    .mode_active        (mode_active)
  );

  host_port_master host_port_master_i (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .use_chip_sel(use_chip_sel),
    .cmd_valid   (cmd_valid),
    .cmd_write   (cmd_write),
    .cmd_relatch (cmd_relatch),
    .cmd_be      (cmd_be),
    .cmd_addr    (cmd_addr),
    .cmd_wdata   (cmd_wdata),
    .cmd_ready   (cmd_ready),
    .rsp_valid   (rsp_valid),
    .rsp_rdata   (rsp_rdata),
    .port        (port_if)
  );

  host_port_chk host_port_chk_i (
    .sys_clk             (sys_clk),
    .reset               (reset),
    .chip_sel            (port_if.chip_sel),
    .address_latch_strobe(port_if.address_latch_strobe),
    .read_not_write      (port_if.read_not_write),
    .low_byte_strobe     (port_if.low_byte_strobe),
    .high_byte_strobe    (port_if.high_byte_strobe),
    .ad_host_out         (port_if.ad_host_out),
    .ad_host_oe          (port_if.ad_host_oe),
    .ad_dev_oe           (port_if.ad_dev_oe)
  );

  // read data pattern of the memory behind the device
  function automatic logic [15:0] rd_pat(input logic [13:0] a);
    return {2'h2, a} ^ 16'h5A3C;
  endfunction : rd_pat

  initial forever #12.5 sys_clk = ~sys_clk;

  // memory answers from the latched address
  always @(negedge sys_clk) mem_rdata <= rd_pat(mem_addr);

  // access counter and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (mem_req === 1'b1) req_count++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic do_reset(input logic [2:0] s);
    strap = s;
    reset = 1'b1;
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask : do_reset

  // one host command; live says whether the device should act on it
  task automatic do_cmd(input row_t r, input bit live);
    int          n;
    logic [15:0] m;
    n = req_count;
    m = {{8{r.be[1]}}, {8{r.be[0]}}};
    use_chip_sel = r.cs;
    cmd_write = r.wr;
    cmd_relatch = r.rl;
    cmd_be = r.be;
    cmd_addr = r.addr;
    cmd_wdata = r.wd;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    if (live) begin
      for (int k = 0; k < 100 && mem_req !== 1'b1; k++) @(negedge sys_clk);
      chk(16'(mem_addr), 16'(r.ea));
      chk(16'(mem_we), 16'(r.wr));
      chk(16'(mem_be), r.wr ? 16'(r.be) : 16'h0003);
      if (r.wr) chk(mem_wdata & m, r.wd & m);
      else begin
        for (int k = 0; k < 100 && rsp_valid !== 1'b1; k++)
          @(negedge sys_clk);
        chk(rsp_rdata, rd_pat(r.ea));
      end
    end
    repeat (30) @(negedge sys_clk);
    chk(16'(req_count - n), live ? 16'h0001 : 16'h0000);
  endtask : do_cmd

  initial begin
    do_reset(3'h7);
    chk(16'(mode_active), 16'h0001);
    chk(port_if.ad_dev_oe, 16'h0000);
    foreach (rows[i]) do_cmd(rows[i], 1'b1);
    // soft reset keeps the latched address and the mode; straps moved
    strap = 3'h5;
    sys_reset = 1'b1;
    @(negedge sys_clk);
    sys_reset = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(16'(mode_active), 16'h0001);
    do_cmd({3'b110, 2'h3, 14'h0001, 16'h1357, 14'h1234}, 1'b1);
    // straps not all high: strobes are ignored
    do_reset(3'h6);
    chk(16'(mode_active), 16'h0000);
    do_cmd({3'b111, 2'h3, 14'h0222, 16'h2468, 14'h0222}, 1'b0);
    close_out();
  end
endmodule : mux16_byte_select_host_port_bench
